// >>> rtl/gpio_bank_pkg.sv
// Constants, reset values and carrier types of the pin data port bank.
// Assumes one clock domain and one standby power-on reset for all state.
// What this block does
// - Each pin has one data bit and its own eight-bit configuration register.
// - Pin data bits are packed into eight-bit data registers, groups one to four and eight.
// - Reading an input pin's data bit returns the level present on the pin XOR its polarity bit.
// - For an output pin with main power on, the written data bit XOR its polarity bit is driven onto the pin; open-drain pins only pull low.
// - Data register contents are latched on every read and every write access of the path that select_req picks, while clk_en is high.
// - All registers reachable from runtime block and from configuration-space path.
// - Groups one to four sit at 4B, 4C, 4D, 4E; group one bit n is bus data n.
// - Event-capable pins feed wake logic from standby supply, even with main power off.
// - Group four bit 3 serves disable-control/event-trigger pin; bits 4 to 7 reserved.
// - Configuration bit 0 is direction, bit 1 polarity, bit 7 open-drain select.
// - Group eight sits at 4A; its eight bits serve eight dedicated pins.
package gpio_bank_pkg;
   localparam int NUM_PINS = 36;
   localparam logic [7:0] OFS_GRP1 = 8'h4B;
   localparam logic [7:0] OFS_GRP2 = 8'h4C;
   localparam logic [7:0] OFS_GRP3 = 8'h4D;
   localparam logic [7:0] OFS_GRP4 = 8'h4E;
   localparam logic [7:0] OFS_GRP8 = 8'h4A;
   localparam logic [7:0] OFS_CFG_BASE = 8'h20;
   localparam logic [5:0] BASE_GRP1 = 6'h00;
   localparam logic [5:0] BASE_GRP2 = 6'h08;
   localparam logic [5:0] BASE_GRP3 = 6'h10;
   localparam logic [5:0] BASE_GRP4 = 6'h18;
   localparam logic [5:0] BASE_GRP8 = 6'h1C;
   localparam logic [5:0] BASE_NONE = 6'h3F;
   localparam logic [7:0] MASK_FULL = 8'hFF;
   localparam logic [7:0] MASK_GRP4 = 8'h0F;
   localparam int CFG_DIR = 0;
   localparam int CFG_POL = 1;
   localparam int CFG_ODRAIN = 7;
   localparam logic [7:0] CFG_RST_INPUT = 8'h01;
   localparam logic [7:0] CFG_RST_OUTPUT = 8'h00;
   localparam logic [5:0] FIRST_OUT_PIN = 6'h1C;
   localparam logic [NUM_PINS-1:0] DATA_RST = 36'hF0000000_0;
   localparam logic [NUM_PINS-1:0] WAKE_PINS = 36'h00EFFFFFF;
   localparam logic [7:0] RDATA_RST = 8'h00;
   localparam logic [7:0] WLATCH_RST = 8'h00;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;
   localparam logic [NUM_PINS-1:0] PAD_RST = 36'h000000000;
   localparam int GRP_BITS = 8;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef logic [NUM_PINS-1:0][7:0] cfg_array_t;
endpackage : gpio_bank_pkg

// >>> rtl/gpio_pin_logic.sv
// Per-pin direction, polarity and driver-type logic, purely combinational.
// Assumes pad inputs are synchronous to the clock of the owning block.
`timescale 1ns/1ps
module gpio_pin_logic
   import gpio_bank_pkg::*;
(
   input wire cfg_array_t cfg,
   input wire logic [NUM_PINS-1:0] data,
   input wire logic [NUM_PINS-1:0] pad_in,
   input wire logic main_power_ok,
   output logic [NUM_PINS-1:0] level,
   output logic [NUM_PINS-1:0] drv_out,
   output logic [NUM_PINS-1:0] drv_oe
);
   logic drive;
   always_comb begin
      drive = 1'b0;
      for (int i = 0; i < NUM_PINS; i++) begin
         // Inputs show the pin XOR polarity, outputs show the stored bit
         level[i] = cfg[i][CFG_DIR] ? (pad_in[i] ^ cfg[i][CFG_POL]) : data[i];
         drive = data[i] ^ cfg[i][CFG_POL];
         if (cfg[i][CFG_DIR] || !main_power_ok) begin
            drv_out[i] = 1'b0;
            drv_oe[i] = 1'b0;
         end else if (cfg[i][CFG_ODRAIN]) begin
            drv_out[i] = 1'b0;
            drv_oe[i] = ~drive;
         end else begin
            drv_out[i] = drive;
            drv_oe[i] = 1'b1;
         end
      end
   end
endmodule : gpio_pin_logic

// >>> rtl/gpio_data_port_bank.sv
// Top of the pin data port bank: data cells, configuration registers, access ports.
// Assumes two byte-wide access paths, one clock, reset asynchronous active high.
`timescale 1ns/1ps
module gpio_data_port_bank
   import gpio_bank_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire reg_req_t runtime_req,
   input wire reg_req_t cfgspace_req,
   output logic [7:0] rdata,
   output logic rdata_valid,
   output logic [7:0] write_latch,
   input wire logic main_power_ok,
   input wire logic [NUM_PINS-1:0] pad_in,
   output logic [NUM_PINS-1:0] pad_out,
   output logic [NUM_PINS-1:0] pad_oe,
   output logic [NUM_PINS-1:0] wake_level
);
   typedef struct packed {
      logic [NUM_PINS-1:0] data;
      cfg_array_t cfg;
      logic [7:0] rdata;
      logic rvalid;
      logic [7:0] wlatch;
      logic [NUM_PINS-1:0] pad_out;
      logic [NUM_PINS-1:0] pad_oe;
      logic [NUM_PINS-1:0] wake;
   } state_t;

   typedef enum logic [1:0] {
      KIND_NONE = 2'b00,
      KIND_DATA = 2'b01,
      KIND_CFG = 2'b10
   } addr_kind_t;

   typedef struct packed {
      logic rd;
      logic wr;
      addr_kind_t kind;
      logic [5:0] base;
      logic [7:0] mask;
      logic [5:0] cidx;
      logic [7:0] wdata;
   } access_t;

   state_t st;
   state_t next_st;
   reg_req_t req;
   access_t dec;
   logic [7:0] read_byte;
   logic [NUM_PINS-1:0] level;
   logic [NUM_PINS-1:0] drv_out;
   logic [NUM_PINS-1:0] drv_oe;

   function automatic logic [5:0] grp_base(input logic [7:0] a);
      unique case (a)
         OFS_GRP1: grp_base = BASE_GRP1;
         OFS_GRP2: grp_base = BASE_GRP2;
         OFS_GRP3: grp_base = BASE_GRP3;
         OFS_GRP4: grp_base = BASE_GRP4;
         OFS_GRP8: grp_base = BASE_GRP8;
         default: grp_base = BASE_NONE;
      endcase
   endfunction : grp_base

   function automatic logic [7:0] grp_mask(input logic [7:0] a);
      grp_mask = (a == OFS_GRP4) ? MASK_GRP4 : MASK_FULL;
   endfunction : grp_mask

   function automatic cfg_array_t cfg_reset();
      for (int i = 0; i < NUM_PINS; i++) begin
         cfg_reset[i] = (i < int'(FIRST_OUT_PIN)) ? CFG_RST_INPUT : CFG_RST_OUTPUT;
      end
   endfunction : cfg_reset

   localparam cfg_array_t CFG_RST = cfg_reset();

   function automatic logic is_active(input reg_req_t r);
      is_active = r.rd || r.wr;
   endfunction : is_active

   function automatic reg_req_t select_req(
      input reg_req_t rt,
      input reg_req_t cs
   );
      // Runtime block takes precedence when both paths access together
      if (is_active(rt)) begin
         select_req = rt;
      end else begin
         select_req = cs;
      end
   endfunction : select_req

   function automatic logic is_cfg_addr(input logic [7:0] a);
      logic [8:0] top;
      top = {1'b0, OFS_CFG_BASE} + 9'(NUM_PINS);
      is_cfg_addr = (a >= OFS_CFG_BASE) && ({1'b0, a} < top);
   endfunction : is_cfg_addr

   function automatic logic [5:0] cfg_index(input logic [7:0] a);
      logic [7:0] ofs;
      ofs = a - OFS_CFG_BASE;
      cfg_index = ofs[5:0];
   endfunction : cfg_index

   function automatic addr_kind_t addr_kind(input logic [7:0] a);
      if (grp_base(a) != BASE_NONE) begin
         addr_kind = KIND_DATA;
      end else if (is_cfg_addr(a)) begin
         addr_kind = KIND_CFG;
      end else begin
         addr_kind = KIND_NONE;
      end
   endfunction : addr_kind

   function automatic access_t decode_access(input reg_req_t r);
      access_t d;
      d.rd = r.rd;
      d.wr = r.wr;
      d.kind = addr_kind(r.addr);
      d.base = grp_base(r.addr);
      d.mask = grp_mask(r.addr);
      d.cidx = cfg_index(r.addr);
      d.wdata = r.wdata;
      decode_access = d;
   endfunction : decode_access

   function automatic int pin_of(
      input logic [5:0] base,
      input int bit_pos
   );
      pin_of = int'(base) + bit_pos;
   endfunction : pin_of

   function automatic logic pin_in_group(
      input access_t d,
      input int bit_pos
   );
      logic in_range;
      in_range = pin_of(d.base, bit_pos) < NUM_PINS;
      pin_in_group = (d.kind == KIND_DATA) && d.mask[bit_pos] && in_range;
   endfunction : pin_in_group

   function automatic logic [7:0] read_group(
      input access_t d,
      input logic [NUM_PINS-1:0] lvl
   );
      logic [7:0] b;
      b = UNMAPPED_RD;
      for (int i = 0; i < GRP_BITS; i++) begin
         if (pin_in_group(d, i)) begin
            b[i] = lvl[pin_of(d.base, i)];
         end
      end
      read_group = b;
   endfunction : read_group

   function automatic logic [NUM_PINS-1:0] write_group(
      input access_t d,
      input logic [NUM_PINS-1:0] cur
   );
      logic [NUM_PINS-1:0] v;
      v = cur;
      for (int i = 0; i < GRP_BITS; i++) begin
         if (pin_in_group(d, i)) begin
            v[pin_of(d.base, i)] = d.wdata[i];
         end
      end
      write_group = v;
   endfunction : write_group

   function automatic logic [7:0] read_cfg(
      input access_t d,
      input cfg_array_t c
   );
      if (d.kind == KIND_CFG) begin
         read_cfg = c[d.cidx];
      end else begin
         read_cfg = UNMAPPED_RD;
      end
   endfunction : read_cfg

   function automatic cfg_array_t write_cfg(
      input access_t d,
      input cfg_array_t c
   );
      cfg_array_t v;
      v = c;
      if (d.kind == KIND_CFG) begin
         v[d.cidx] = d.wdata;
      end
      write_cfg = v;
   endfunction : write_cfg

   function automatic logic [7:0] read_access(
      input access_t d,
      input logic [NUM_PINS-1:0] lvl,
      input cfg_array_t c
   );
      unique case (d.kind)
         KIND_DATA: read_access = read_group(d, lvl);
         KIND_CFG: read_access = read_cfg(d, c);
         default: read_access = UNMAPPED_RD;
      endcase
   endfunction : read_access

   function automatic logic [7:0] latch_mask(input access_t d);
      if (d.kind == KIND_DATA) begin
         latch_mask = d.mask;
      end else begin
         latch_mask = MASK_FULL;
      end
   endfunction : latch_mask

   function automatic state_t apply_read(
      input state_t s,
      input access_t d,
      input logic [7:0] b
   );
      state_t v;
      v = s;
      v.rvalid = d.rd;
      if (d.rd) begin
         v.rdata = b;
      end
      apply_read = v;
   endfunction : apply_read

   function automatic state_t apply_write(
      input state_t s,
      input access_t d
   );
      state_t v;
      v = s;
      if (d.wr) begin
         v.data = write_group(d, s.data);
         v.cfg = write_cfg(d, s.cfg);
         v.wlatch = d.wdata & latch_mask(d);
      end
      apply_write = v;
   endfunction : apply_write

   function automatic state_t apply_pins(
      input state_t s,
      input logic [NUM_PINS-1:0] out,
      input logic [NUM_PINS-1:0] oe,
      input logic [NUM_PINS-1:0] pins
   );
      state_t v;
      v = s;
      v.pad_out = out;
      v.pad_oe = oe;
      // Wake path ignores main power and configuration
      v.wake = pins & WAKE_PINS;
      apply_pins = v;
   endfunction : apply_pins

   function automatic state_t state_reset();
      state_t s;
      s.data = DATA_RST;
      s.cfg = CFG_RST;
      s.rdata = RDATA_RST;
      s.rvalid = 1'b0;
      s.wlatch = WLATCH_RST;
      s.pad_out = PAD_RST;
      s.pad_oe = PAD_RST;
      s.wake = PAD_RST;
      state_reset = s;
   endfunction : state_reset

   localparam state_t ST_RST = state_reset();

   gpio_pin_logic u_pins (
      .cfg(st.cfg),
      .data(st.data),
      .pad_in(pad_in),
      .main_power_ok(main_power_ok),
      .level(level),
      .drv_out(drv_out),
      .drv_oe(drv_oe)
   );

   assign req = select_req(runtime_req, cfgspace_req);
   assign dec = decode_access(req);
   assign read_byte = read_access(dec, level, st.cfg);

   always_comb begin
      next_st = apply_read(st, dec, read_byte);
      next_st = apply_write(next_st, dec);
      next_st = apply_pins(next_st, drv_out, drv_oe, pad_in);
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st <= ST_RST;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign rdata_valid = st.rvalid;
   assign write_latch = st.wlatch;
   assign pad_out = st.pad_out;
   assign pad_oe = st.pad_oe;
   assign wake_level = st.wake;
endmodule : gpio_data_port_bank

// >>> test/gpio_bank_sva.sv
// Port checker of the pin data port bank.
// Assumes one clock and the bank's own reset.
`timescale 1ns/1ps
module gpio_bank_sva
   import gpio_bank_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire reg_req_t runtime_req,
   input wire reg_req_t cfgspace_req,
   input wire logic [7:0] rdata,
   input wire logic rdata_valid,
   input wire logic [7:0] write_latch,
   input wire logic main_power_ok,
   input wire logic [NUM_PINS-1:0] pad_in,
   input wire logic [NUM_PINS-1:0] pad_oe,
   input wire logic [NUM_PINS-1:0] wake_level
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   wire logic rrd = clk_en && runtime_req.rd;
   wire logic any_rd = clk_en && (runtime_req.rd || cfgspace_req.rd);
   wire logic wr1 = clk_en && runtime_req.wr && runtime_req.addr == OFS_GRP1;
   wire logic wr4 = clk_en && runtime_req.wr && runtime_req.addr == OFS_GRP4;
   a_read_answer: assert property (rrd |=> rdata_valid)
      else $error("read not answered");
   a_answer_cause: assert property (rdata_valid && $past(clk_en) |-> $past(any_rd))
      else $error("answer without read");
   a_write_latch: assert property (wr1 |=> write_latch == $past(runtime_req.wdata))
      else $error("write not latched");
   a_group4_mask: assert property (wr4 |=> write_latch[7:4] == 4'h0)
      else $error("reserved bits latched");
   a_power_off: assert property (clk_en && !main_power_ok |=> pad_oe == '0)
      else $error("pin driven without power");
   a_wake_path: assert property (clk_en |=> wake_level == ($past(pad_in) & WAKE_PINS))
      else $error("wake level wrong");
   a_unmapped_rd: assert property (rrd && runtime_req.addr == 8'h00 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!rdata_valid |-> $stable(rdata))
      else $error("read data moved");
   c_read: cover property (rdata_valid);
   c_write: cover property (wr1);
   c_power: cover property (!main_power_ok);
   c_freeze: cover property (!clk_en);
endmodule : gpio_bank_sva
bind gpio_data_port_bank gpio_bank_sva u_sva(.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
   .runtime_req(runtime_req), .cfgspace_req(cfgspace_req), .rdata(rdata),
   .rdata_valid(rdata_valid), .write_latch(write_latch), .main_power_ok(main_power_ok),
   .pad_in(pad_in), .pad_oe(pad_oe), .wake_level(wake_level));

// >>> test/board_model.sv
// Board seen at the pins of the bank.
// Assumes released pins settle to the board level.
`timescale 1ns/1ps
module board_model
   import gpio_bank_pkg::*;
(
   input wire logic [NUM_PINS-1:0] pad_out,
   input wire logic [NUM_PINS-1:0] pad_oe,
   input wire logic [NUM_PINS-1:0] board_level,
   output logic [NUM_PINS-1:0] pad_in
);
   assign pad_in = (pad_out & pad_oe) | (board_level & ~pad_oe);
endmodule : board_model

// >>> test/testbench.sv
// Self-checking bench of the pin data port bank.
// Assumes the board model on the pins.
`timescale 1ns/1ps
module testbench
   import gpio_bank_pkg::*;
;
   logic sys_clk, reset, clk_en, main_power_ok, rdata_valid;
   reg_req_t rq, cq;
   logic [7:0] rdata, write_latch;
   logic [NUM_PINS-1:0] pad_in, pad_out, pad_oe, wake_level, board;
   int num_errors = 0;
   int checked = 0;
   gpio_data_port_bank dut(.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .runtime_req(rq),
      .cfgspace_req(cq), .rdata(rdata), .rdata_valid(rdata_valid), .write_latch(write_latch),
      .main_power_ok(main_power_ok), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .wake_level(wake_level));
   board_model brd(.pad_out(pad_out), .pad_oe(pad_oe), .board_level(board), .pad_in(pad_in));
   initial begin
      sys_clk = 0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic acc(input bit cs, input logic r, input logic w, input logic [7:0] a,
      input logic [7:0] d);
      @(negedge sys_clk);
      if (cs) cq <= {r, w, a, d};
      else rq <= {r, w, a, d};
      @(negedge sys_clk);
      rq <= '0;
      cq <= '0;
   endtask : acc
   task automatic t_inputs();
      logic [7:0] ofs [4] = '{OFS_GRP1, OFS_GRP2, OFS_GRP3, OFS_GRP4};
      chk("reset oe", 36'hFF0000000, pad_oe);
      chk("reset out", 36'hF00000000, pad_out);
      acc(0, 1, 0, OFS_GRP8, 8'h00);
      chk("group8 read", 8'hF0, rdata);
      chk("read valid", 1'b1, rdata_valid);
      board = 36'h05A3C96A5;
      for (int g = 0; g < 4; g++) begin
         acc(g[0], 1, 0, ofs[g], 8'h00);
         chk("input read", (g == 3) ? 8'h0A : board[8*g +: 8], rdata);
      end
      main_power_ok = 0;
      @(negedge sys_clk);
      chk("unpowered oe", 36'h0, pad_oe);
      chk("wake level", board & WAKE_PINS, wake_level);
      main_power_ok = 1;
      $display("input test done");
   endtask : t_inputs
   task automatic t_drive();
      logic [7:0] cfg [4] = '{8'h00, 8'h02, 8'h80, 8'h82};
      logic [1:0] exp [4] = '{2'b10, 2'b11, 2'b10, 2'b00};
      acc(0, 0, 1, OFS_GRP1, 8'h00);
      for (int i = 0; i < 4; i++) begin
         acc(1, 0, 1, OFS_CFG_BASE, cfg[i]);
         @(negedge sys_clk);
         chk("pin0 drive", exp[i], {pad_oe[0], pad_out[0]});
      end
      acc(0, 1, 0, OFS_GRP1, 8'h00);
      chk("output readback", 8'hA4, rdata);
      acc(0, 0, 1, OFS_GRP4, 8'hFF);
      chk("group4 latch", 8'h0F, write_latch);
      acc(0, 1, 0, 8'h00, 8'h00);
      chk("unmapped read", 8'h00, rdata);
      $display("drive test done");
   endtask : t_drive
   task automatic t_freeze();
      @(negedge sys_clk);
      clk_en = 0;
      acc(0, 0, 1, OFS_GRP8, 8'h00);
      acc(0, 1, 0, OFS_GRP1, 8'h00);
      chk("frozen valid", 1'b0, rdata_valid);
      chk("frozen latch", 8'h0F, write_latch);
      chk("frozen drive", 36'hF00000000, pad_out);
      clk_en = 1;
      $display("freeze test done");
   endtask : t_freeze
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   initial begin
      reset = 1;
      clk_en = 1;
      main_power_ok = 1;
      rq = '0;
      cq = '0;
      board = '0;
      repeat (20) @(negedge sys_clk);
      reset = 0;
      @(negedge sys_clk);
      t_inputs();
      t_drive();
      t_freeze();
      test_done();
   end
   initial begin
      #100000;
      num_errors++;
      test_done();
   end
endmodule : testbench
